/* File: logic/umpi_channel.sv */
`timescale 1ns/1ps
module umpi_channel (
	input wire logic CLOCK_I, // 50 MHz device clock
	input wire logic RST_I, // synchronous reset, active high
	input wire logic CYC_I, // wishbone cycle
	input wire logic STB_I, // wishbone strobe
	input wire logic WE_I, // wishbone write enable
	input wire logic [4:2] ADR_I, // wishbone word address
	input wire logic [3:0] SEL_I, // wishbone byte selects
	input wire logic [31:0] DAT_I, // wishbone write data
	output logic [31:0] DAT_O, // wishbone read data
	output logic ACK_O, // wishbone acknowledge
	input wire logic SERIAL_IN_I, // receive data pin
	output logic SERIAL_OUT_O, // transmit data pin
	output logic REQUEST_TO_SEND_N_O, // request-to-send, active low
	input wire logic CLEAR_TO_SEND_N_I, // clear-to-send, active low
	output logic TERMINAL_READY_N_O, // terminal-ready, active low
	input wire logic SET_READY_N_I, // data-set-ready, active low
	input wire logic CARRIER_DETECT_N_I, // carrier detect, active low
	input wire logic RING_INDICATOR_N_I, // ring indicator, active low
	output logic MULTI_FUNCTION_OUT_N_O // multi-function output, active low
);
	// ***************************************************************
	// declarations
	// ***************************************************************
	logic [7:0] int_en_q;
	logic [7:0] enh_q;
	logic [7:0] modem_q;
	logic [7:0] alt_q;
	logic [15:0] div_q;
	logic [31:0] dat_q;
	logic ack_q;
	logic [4:0] pin_m_q;
	logic [4:0] pin_s_q;
	logic [15:0] div_cnt_q;
	logic tick;
	logic baud_clk;
	umpi_pkg::umpi_tx_e tx_state_q;
	logic [3:0] tx_tick_q;
	logic [2:0] tx_bit_q;
	logic [7:0] tx_sh_q;
	logic tx_line;
	logic tx_pin_q;
	umpi_pkg::umpi_rx_e rx_state_q;
	logic [3:0] rx_tick_q;
	logic [2:0] rx_bit_q;
	logic [7:0] rx_sh_q;
	logic [7:0] rx_hold_q;
	logic rx_ready_q;
	logic rx_done;
	logic [3:0] ir_stretch_q;
	logic rx_ir_in;
	logic rx_line;
	logic rts_n_q;
	logic dtr_n_q;
	logic mf_n_q;
	logic req;
	logic wr;
	logic rd;
	logic cts_block;
	logic rx_read;

	umpi_stream_if #(.W(umpi_pkg::DATA_W)) fill_if ();
	umpi_stream_if #(.W(umpi_pkg::DATA_W)) drain_if ();

	// decoding of the word address, used by writes and reads alike
	function automatic logic hit(input logic [2:0] adr, input logic [2:0] idx);
		hit = (adr == idx);
	endfunction : hit

	// ***************************************************************
	// wishbone slave
	// ***************************************************************
	assign req = CYC_I & STB_I & ~ack_q;
	// a transmit write to a full fifo stalls the bus until room appears
	assign fill_if.valid = req & WE_I & SEL_I[0] & hit(ADR_I, umpi_pkg::IDX_DATA);
	assign fill_if.data = DAT_I[7:0];
	assign wr = req & WE_I & ~(fill_if.valid & ~fill_if.ready);
	assign rd = req & ~WE_I;
	assign rx_read = rd & hit(ADR_I, umpi_pkg::IDX_DATA);
	assign ACK_O = ack_q;
	assign DAT_O = dat_q;

	// acknowledge one cycle after the request, dropped the cycle after
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= rd | wr;
		end
	end

	// control registers cleared by reset, divisor loaded with 0x001B
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			int_en_q <= umpi_pkg::CTRL_RST;
			enh_q <= umpi_pkg::CTRL_RST;
			modem_q <= umpi_pkg::CTRL_RST;
			alt_q <= umpi_pkg::CTRL_RST;
			div_q <= umpi_pkg::DIV_RST;
		end else if (wr) begin
			if (SEL_I[0] && hit(ADR_I, umpi_pkg::IDX_INT_EN)) begin
				int_en_q <= DAT_I[7:0];
			end
			if (SEL_I[0] && hit(ADR_I, umpi_pkg::IDX_ENH)) begin
				enh_q <= DAT_I[7:0];
			end
			if (SEL_I[0] && hit(ADR_I, umpi_pkg::IDX_MODEM)) begin
				modem_q <= DAT_I[7:0];
			end
			if (SEL_I[0] && hit(ADR_I, umpi_pkg::IDX_ALT)) begin
				alt_q <= DAT_I[7:0];
			end
			if (hit(ADR_I, umpi_pkg::IDX_DIV)) begin
				if (SEL_I[0]) begin
					div_q[7:0] <= DAT_I[7:0];
				end
				if (SEL_I[1]) begin
					div_q[15:8] <= DAT_I[15:8];
				end
			end
		end
	end

	// read data, unmapped words read as zero
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			dat_q <= '0;
		end else if (rd) begin
			unique case (ADR_I)
				umpi_pkg::IDX_DATA: dat_q <= {24'h000000, rx_hold_q};
				umpi_pkg::IDX_INT_EN: dat_q <= {24'h000000, int_en_q};
				umpi_pkg::IDX_ENH: dat_q <= {24'h000000, enh_q};
				umpi_pkg::IDX_MODEM: dat_q <= {24'h000000, modem_q};
				umpi_pkg::IDX_ALT: dat_q <= {24'h000000, alt_q};
				umpi_pkg::IDX_STATUS: dat_q <= {24'h000000, ~pin_s_q[3:0], ~fill_if.ready,
						~drain_if.valid, (tx_state_q != umpi_pkg::TX_IDLE), rx_ready_q};
				umpi_pkg::IDX_DIV: dat_q <= {16'h0000, div_q};
				default: dat_q <= '0;
			endcase
		end
	end

	// ***************************************************************
	// pin synchronisers and baud divider
	// ***************************************************************
	// order: receive, clear-to-send, set-ready, carrier, ring
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			pin_m_q <= 5'h1F;
			pin_s_q <= 5'h1F;
		end else begin
			pin_m_q <= {SERIAL_IN_I, CLEAR_TO_SEND_N_I, SET_READY_N_I, CARRIER_DETECT_N_I, RING_INDICATOR_N_I};
			pin_s_q <= pin_m_q;
		end
	end

	// 16x tick; a divisor of zero behaves as one
	assign tick = ((div_cnt_q + 16'h0001) >= div_q);
	assign baud_clk = (div_cnt_q >= {1'b0, div_q[15:1]});

	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			div_cnt_q <= '0;
		end else if (tick) begin
			div_cnt_q <= '0;
		end else begin
			div_cnt_q <= div_cnt_q + 16'h0001;
		end
	end

	// ***************************************************************
	// transmitter
	// ***************************************************************
	umpi_fifo #(.W(umpi_pkg::DATA_W), .DEPTH(umpi_pkg::FIFO_DEPTH)) u_tx_fifo (
		.clk_i(CLOCK_I),
		.rst_i(RST_I),
		.fill(fill_if),
		.drain(drain_if)
	);

	// a high clear-to-send holds the next character back in auto mode
	assign cts_block = enh_q[umpi_pkg::EF_AUTO_CTS] & pin_s_q[3];
	assign drain_if.ready = (tx_state_q == umpi_pkg::TX_IDLE) & ~cts_block;

	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			tx_state_q <= umpi_pkg::TX_IDLE;
			tx_tick_q <= '0;
			tx_bit_q <= '0;
			tx_sh_q <= '0;
		end else begin
			unique case (tx_state_q)
				umpi_pkg::TX_IDLE: begin
					if (drain_if.valid && drain_if.ready) begin
						tx_sh_q <= drain_if.data;
						tx_tick_q <= '0;
						tx_bit_q <= '0;
						tx_state_q <= umpi_pkg::TX_START;
					end
				end
				umpi_pkg::TX_START: begin
					if (tick) begin
						tx_tick_q <= tx_tick_q + 4'h1;
						if (tx_tick_q == umpi_pkg::TICK_LAST) begin
							tx_state_q <= umpi_pkg::TX_DATA;
						end
					end
				end
				umpi_pkg::TX_DATA: begin
					if (tick) begin
						tx_tick_q <= tx_tick_q + 4'h1;
						if (tx_tick_q == umpi_pkg::TICK_LAST) begin
							tx_sh_q <= {1'b0, tx_sh_q[7:1]};
							tx_bit_q <= tx_bit_q + 3'h1;
							if (tx_bit_q == umpi_pkg::BIT_LAST) begin
								tx_state_q <= umpi_pkg::TX_STOP;
							end
						end
					end
				end
				umpi_pkg::TX_STOP: begin
					if (tick) begin
						tx_tick_q <= tx_tick_q + 4'h1;
						if (tx_tick_q == umpi_pkg::TICK_LAST) begin
							tx_state_q <= umpi_pkg::TX_IDLE;
						end
					end
				end
				default: tx_state_q <= umpi_pkg::TX_IDLE;
			endcase
		end
	end

	// line level: start low, data lsb first, stop and idle high
	assign tx_line = (tx_state_q == umpi_pkg::TX_START) ? 1'b0 :
			(tx_state_q == umpi_pkg::TX_DATA) ? tx_sh_q[0] : 1'b1;

	// infrared sends a short high pulse per zero bit and otherwise rests low
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			tx_pin_q <= 1'b1;
		end else if (modem_q[umpi_pkg::MC_IR]) begin
			tx_pin_q <= ~tx_line & (tx_tick_q < umpi_pkg::IR_PULSE_TICKS);
		end else begin
			tx_pin_q <= tx_line;
		end
	end
	assign SERIAL_OUT_O = tx_pin_q;

	// ***************************************************************
	// receiver
	// ***************************************************************
	// optional inversion sits ahead of the decoder
	assign rx_ir_in = modem_q[umpi_pkg::MC_RX_INV] ? ~pin_s_q[4] : pin_s_q[4];

	// a pulse is stretched over one bit so the mid-bit sample sees it;
	// only loaded in infrared mode, else a high normal line leaves a false start behind
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			ir_stretch_q <= '0;
		end else if (modem_q[umpi_pkg::MC_IR] && rx_ir_in) begin
			ir_stretch_q <= umpi_pkg::TICK_LAST;
		end else if (tick && ir_stretch_q != '0) begin
			ir_stretch_q <= ir_stretch_q - 4'h1;
		end
	end

	// the remote idles the normal line high, low means a start bit
	assign rx_line = modem_q[umpi_pkg::MC_IR] ? (ir_stretch_q == '0) : pin_s_q[4];
	assign rx_done = (rx_state_q == umpi_pkg::RX_STOP) & tick & (rx_tick_q == umpi_pkg::TICK_LAST);

	// held in idle through reset, so the line is ignored then
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			rx_state_q <= umpi_pkg::RX_IDLE;
			rx_tick_q <= '0;
			rx_bit_q <= '0;
			rx_sh_q <= '0;
		end else if (tick) begin
			rx_tick_q <= rx_tick_q + 4'h1;
			unique case (rx_state_q)
				umpi_pkg::RX_IDLE: begin
					rx_tick_q <= '0;
					if (!rx_line) begin
						rx_state_q <= umpi_pkg::RX_START;
					end
				end
				umpi_pkg::RX_START: begin
					if (rx_tick_q == umpi_pkg::HALF_BIT_LAST) begin
						rx_tick_q <= '0;
						rx_bit_q <= '0;
						rx_state_q <= rx_line ? umpi_pkg::RX_IDLE : umpi_pkg::RX_DATA;
					end
				end
				umpi_pkg::RX_DATA: begin
					if (rx_tick_q == umpi_pkg::TICK_LAST) begin
						rx_sh_q <= {rx_line, rx_sh_q[7:1]};
						rx_bit_q <= rx_bit_q + 3'h1;
						if (rx_bit_q == umpi_pkg::BIT_LAST) begin
							rx_state_q <= umpi_pkg::RX_STOP;
						end
					end
				end
				umpi_pkg::RX_STOP: begin
					if (rx_tick_q == umpi_pkg::TICK_LAST) begin
						rx_state_q <= umpi_pkg::RX_IDLE;
					end
				end
				default: rx_state_q <= umpi_pkg::RX_IDLE;
			endcase
		end
	end

	// one-character holding register; a new arrival beats a read clear
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			rx_hold_q <= '0;
			rx_ready_q <= 1'b0;
		end else if (rx_done) begin
			rx_hold_q <= rx_sh_q;
			rx_ready_q <= 1'b1;
		end else if (rx_read) begin
			rx_ready_q <= 1'b0;
		end
	end

	// ***************************************************************
	// modem outputs and multi-function pin
	// ***************************************************************
	// auto mode lifts request-to-send while a character waits unread
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			rts_n_q <= 1'b1;
			dtr_n_q <= 1'b1;
		end else begin
			rts_n_q <= ~modem_q[umpi_pkg::MC_RTS] | (enh_q[umpi_pkg::EF_AUTO_RTS] & rx_ready_q);
			dtr_n_q <= ~modem_q[umpi_pkg::MC_DTR];
		end
	end

	// the unused fourth code falls back to the general output
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			mf_n_q <= 1'b1;
		end else begin
			unique case (alt_q[umpi_pkg::AF_SEL_LO +: 2])
				umpi_pkg::MF_BAUD: mf_n_q <= baud_clk;
				umpi_pkg::MF_RXRDY: mf_n_q <= ~rx_ready_q;
				default: mf_n_q <= ~modem_q[umpi_pkg::MC_OP2];
			endcase
		end
	end

	assign REQUEST_TO_SEND_N_O = rts_n_q;
	assign TERMINAL_READY_N_O = dtr_n_q;
	assign MULTI_FUNCTION_OUT_N_O = mf_n_q;

	// ***************************************************************
	// assertions
	// ***************************************************************
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (RST_I);

	sequence s_pop;
		drain_if.valid && drain_if.ready;
	endsequence
	sequence s_char_in;
		rx_done ##1 rx_ready_q;
	endsequence

	AST_TX_IDLE_HIGH: assert property ((tx_state_q == umpi_pkg::TX_IDLE) && !modem_q[umpi_pkg::MC_IR] |=> SERIAL_OUT_O) else $error("idle normal line not high");
	AST_IR_IDLE_LOW: assert property ((tx_state_q == umpi_pkg::TX_IDLE) && modem_q[umpi_pkg::MC_IR] |=> !SERIAL_OUT_O) else $error("idle infrared line not low");
	AST_RESET_TX_HIGH: assert property (@(posedge CLOCK_I) disable iff (1'b0) RST_I |=> SERIAL_OUT_O) else $error("transmit not high after reset");
	AST_RESET_OP2: assert property (@(posedge CLOCK_I) disable iff (1'b0) RST_I |=> !modem_q[umpi_pkg::MC_OP2] && MULTI_FUNCTION_OUT_N_O) else $error("output-two not cleared");
	AST_CTS_GATE: assert property (cts_block && (tx_state_q == umpi_pkg::TX_IDLE) |=> tx_state_q == umpi_pkg::TX_IDLE) else $error("transmit started while blocked");
	AST_POP_START: assert property (s_pop |=> (tx_state_q == umpi_pkg::TX_START) ##1 !SERIAL_OUT_O || modem_q[umpi_pkg::MC_IR]) else $error("start bit missing");
	AST_MF_OP2: assert property (alt_q[2:1] == umpi_pkg::MF_OP2 |=> MULTI_FUNCTION_OUT_N_O == !$past(modem_q[3])) else $error("general output wrong");
	AST_MF_BAUD: assert property (alt_q[2:1] == umpi_pkg::MF_BAUD |=> MULTI_FUNCTION_OUT_N_O == $past(baud_clk)) else $error("baud clock not on pin");
	AST_MF_RXRDY: assert property (s_char_in ##0 (alt_q[2:1] == umpi_pkg::MF_RXRDY) |=> !MULTI_FUNCTION_OUT_N_O) else $error("receive-ready not low");
	AST_RX_READY_CLR: assert property (rx_read && !rx_done |=> !rx_ready_q) else $error("receive-ready not cleared by read");
	AST_DTR: assert property (1'b1 |=> TERMINAL_READY_N_O == !$past(modem_q[umpi_pkg::MC_DTR])) else $error("terminal-ready wrong");
	AST_RX_INV: assert property (modem_q[umpi_pkg::MC_IR] && modem_q[umpi_pkg::MC_RX_INV] && !pin_s_q[4] |=> ir_stretch_q == umpi_pkg::TICK_LAST) else $error("inverted pulse missed");
endmodule : umpi_channel

/* File: logic/umpi_pkg.sv */
// ***************************************************************
// shared constants of the modem pin interface
// ***************************************************************
package umpi_pkg;
	// clock and reset timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int RESET_MIN_NS = 40;
	localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// register word indices, byte address is four times the index
	localparam logic [2:0] IDX_DATA = 3'h0;
	localparam logic [2:0] IDX_INT_EN = 3'h1;
	localparam logic [2:0] IDX_ENH = 3'h2;
	localparam logic [2:0] IDX_MODEM = 3'h3;
	localparam logic [2:0] IDX_ALT = 3'h4;
	localparam logic [2:0] IDX_STATUS = 3'h5;
	localparam logic [2:0] IDX_DIV = 3'h6;
	// modem control field positions
	localparam int MC_DTR = 0;
	localparam int MC_RTS = 1;
	localparam int MC_RX_INV = 2;
	localparam int MC_OP2 = 3;
	localparam int MC_IR = 6;
	// enhanced feature field positions
	localparam int EF_AUTO_RTS = 6;
	localparam int EF_AUTO_CTS = 7;
	// alternate function select field and its codes
	localparam int AF_SEL_LO = 1;
	localparam logic [1:0] MF_OP2 = 2'h0;
	localparam logic [1:0] MF_BAUD = 2'h1;
	localparam logic [1:0] MF_RXRDY = 2'h2;
	// status field positions
	localparam int ST_RX_READY = 0;
	localparam int ST_TX_BUSY = 1;
	localparam int ST_FIFO_EMPTY = 2;
	localparam int ST_FIFO_FULL = 3;
	localparam int ST_PINS_LO = 4;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [15:0] DIV_RST = 16'h001B;
	// serial timing in ticks of the 16x rate, and the last data bit index
	localparam logic [3:0] TICK_LAST = 4'hF;
	localparam logic [3:0] HALF_BIT_LAST = 4'h7;
	localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
	localparam logic [2:0] BIT_LAST = 3'h7;
	// buffering
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 16;
	// state machines
	typedef enum logic [3:0] {
		TX_IDLE = 4'h1,
		TX_START = 4'h2,
		TX_DATA = 4'h4,
		TX_STOP = 4'h8
	} umpi_tx_e;
	typedef enum logic [3:0] {
		RX_IDLE = 4'h1,
		RX_START = 4'h2,
		RX_DATA = 4'h4,
		RX_STOP = 4'h8
	} umpi_rx_e;
endpackage : umpi_pkg

/* File: logic/umpi_stream_if.sv */
`timescale 1ns/1ps
// ***************************************************************
// valid/ready byte stream into and out of the transmit fifo
// ***************************************************************
interface umpi_stream_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : umpi_stream_if

/* File: logic/umpi_fifo.sv */
`timescale 1ns/1ps
// ***************************************************************
// small fifo, read data from a register
// ***************************************************************
module umpi_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk_i, // device clock
	input wire logic rst_i, // synchronous reset, active high
	umpi_stream_if.snk fill, // writer side
	umpi_stream_if.src drain // reader side
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	logic [W-1:0] head_q;
	logic head_vld_q;
	logic push;
	logic pop;

	// full refuses writers, so back-pressure reaches the bus
	assign fill.ready = (count_q != FULL_CNT);
	assign push = fill.valid & fill.ready;
	assign pop = drain.valid & drain.ready;
	assign drain.valid = head_vld_q;
	assign drain.data = head_q;

	// storage has no reset, only the pointers, count and head register have one
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr_q] <= fill.data;
		end
	end

	// pointers and fill level
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			count_q <= count_q + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end

	// head register lags one cycle after a pop so a stale word is never shown
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			head_q <= '0;
			head_vld_q <= 1'b0;
		end else begin
			head_q <= mem[rd_ptr_q];
			head_vld_q <= (count_q != '0) & ~pop;
		end
	end
endmodule : umpi_fifo

/* File: tb/umpi_remote_model.sv */
`timescale 1ns/1ps
// ***************************************************************
// remote serial equipment on the far side of the channel
// ***************************************************************
module umpi_remote_model #(
	parameter int BIT_CYC = 16
) (
	input wire logic clk_i, // device clock, used only for bit timing
	input wire logic line_i, // channel transmit pin
	output logic line_o // channel receive pin
);
	logic [7:0] got_q;
	int count_q;
	int k;
	// remote transmitter rests high between characters
	initial begin
		line_o = 1'b1;
		got_q = 8'h00;
		count_q = 0;
	end
	// one character: start, eight bits lsb first, stop back at the idle level
	task send(input logic [7:0] b);
		line_o <= 1'b0;
		repeat (BIT_CYC) @(posedge clk_i);
		for (int j = 0; j < 8; j++) begin
			line_o <= b[j];
			repeat (BIT_CYC) @(posedge clk_i);
		end
		line_o <= 1'b1;
		repeat (BIT_CYC) @(posedge clk_i);
	endtask : send
	// receiver samples mid-bit; a glitch shorter than half a bit is dropped
	initial begin
		forever begin
			@(negedge line_i);
			repeat (BIT_CYC / 2) @(posedge clk_i);
			if (line_i === 1'b0) begin
				for (k = 0; k < 8; k++) begin
					repeat (BIT_CYC) @(posedge clk_i);
					got_q[k] = line_i;
				end
				repeat (BIT_CYC) @(posedge clk_i);
				count_q++;
			end
		end
	end
endmodule : umpi_remote_model

/* File: tb/uart_modem_pin_interface_tb_top.sv */
`timescale 1ns/1ps
// ***************************************************************
// bench for the modem pin interface channel
// ***************************************************************
module uart_modem_pin_interface_tb_top;
	logic clk, rst, cyc, stb, we, ack, sout, rts_n, dtr_n, mf_n, sin, cts_n, dsr_n, cd_n, ri_n;
	logic [2:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, dato, rdat;
	logic prev;
	int num_errors, check_count, cycles, i, rises;
	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	umpi_channel umpi_channel_inst (.CLOCK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
		.SEL_I(sel), .DAT_I(wdat), .DAT_O(dato), .ACK_O(ack), .SERIAL_IN_I(sin), .SERIAL_OUT_O(sout),
		.REQUEST_TO_SEND_N_O(rts_n), .CLEAR_TO_SEND_N_I(cts_n), .TERMINAL_READY_N_O(dtr_n),
		.SET_READY_N_I(dsr_n), .CARRIER_DETECT_N_I(cd_n), .RING_INDICATOR_N_I(ri_n),
		.MULTI_FUNCTION_OUT_N_O(mf_n));
	umpi_remote_model umpi_remote_model_inst (.clk_i(clk), .line_i(sout), .line_o(sin));
	// closing report, the only place the run ends
	task print_verdict;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : print_verdict
	task check_reg(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check_reg
	task check_pin(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check_pin
	// classic cycle: request held until ack is sampled, then released for a cycle
	task wb(input logic w, input logic [2:0] a, input logic [3:0] s, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		rdat = dato;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb
	task wr(input logic [2:0] a, input logic [31:0] d);
		wb(1'b1, a, 4'h1, d);
	endtask : wr
	task rd(input logic [2:0] a);
		wb(1'b0, a, 4'hF, 32'h00000000);
	endtask : rd
	task ticks(input int n);
		repeat (n) @(posedge clk);
	endtask : ticks
	// bounded wait for the remote end to finish one more character
	task wait_tx(input int n0);
		for (int j = 0; j < 500 && umpi_remote_model_inst.count_q == n0; j++) @(posedge clk);
	endtask : wait_tx
	// hang guard, well above the under two thousand cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 10000) begin
			num_errors++;
			print_verdict();
		end
	end
	initial begin
		{cyc, stb, we, adr, sel, wdat} = '0;
		{rst, cts_n, dsr_n, cd_n, ri_n} = 5'h1F;
		{num_errors, check_count, cycles} = '0;
		repeat (20) @(posedge clk);
		check_pin(sout, 1'b1);
		check_pin(mf_n, 1'b1);
		check_pin(dtr_n, 1'b1);
		rst <= 1'b0;
		cts_n <= 1'b0;
		rd(umpi_pkg::IDX_MODEM);
		check_reg(rdat, 32'h00000000);
		rd(3'h7);
		check_reg(rdat, 32'h00000000);
		// baud clock on the pin: default divisor gives one period per 27 cycles
		wr(umpi_pkg::IDX_ALT, 32'h00000002);
		ticks(4);
		rises = 0;
		prev = mf_n;
		repeat (108) begin
			@(posedge clk);
			if (prev === 1'b0 && mf_n === 1'b1) rises++;
			prev = mf_n;
		end
		check_reg(32'(rises), 32'h00000004);
		wb(1'b1, umpi_pkg::IDX_DIV, 4'h3, 32'h00000001);
		// general output under select codes 0 and 3
		for (i = 0; i < 4; i += 3) begin
			wr(umpi_pkg::IDX_ALT, 32'(i << 1));
			wr(umpi_pkg::IDX_MODEM, 32'h00000008);
			ticks(4);
			check_pin(mf_n, 1'b0);
			wr(umpi_pkg::IDX_MODEM, 32'h00000000);
			ticks(4);
			check_pin(mf_n, 1'b1);
		end
		wr(umpi_pkg::IDX_MODEM, 32'h00000003);
		ticks(4);
		check_pin(dtr_n, 1'b0);
		check_pin(rts_n, 1'b0);
		// status inputs asserted must leave the transmitter alone
		{dsr_n, cd_n, ri_n} <= 3'h0;
		ticks(6);
		rd(umpi_pkg::IDX_STATUS);
		check_reg(rdat & 32'h00000070, 32'h00000070);
		i = umpi_remote_model_inst.count_q;
		wr(umpi_pkg::IDX_DATA, 32'h000000A5);
		wait_tx(i);
		check_reg({24'h000000, umpi_remote_model_inst.got_q}, 32'h000000A5);
		ticks(20);
		check_pin(sout, 1'b1);
		{dsr_n, cd_n, ri_n} <= 3'h7;
		// request-to-send already asserted before auto mode goes on
		wr(umpi_pkg::IDX_ENH, 32'h00000040);
		wr(umpi_pkg::IDX_ALT, 32'h00000004);
		umpi_remote_model_inst.send(8'h3C);
		rdat = 32'h00000000;
		for (i = 0; i < 50 && rdat[0] !== 1'b1; i++) rd(umpi_pkg::IDX_STATUS);
		ticks(3);
		check_pin(mf_n, 1'b0);
		check_pin(rts_n, 1'b1);
		rd(umpi_pkg::IDX_DATA);
		check_reg(rdat, 32'h0000003C);
		ticks(3);
		check_pin(mf_n, 1'b1);
		// clear-to-send withheld: a queued character must wait
		wr(umpi_pkg::IDX_ENH, 32'h000000C0);
		cts_n <= 1'b1;
		ticks(4);
		i = umpi_remote_model_inst.count_q;
		wr(umpi_pkg::IDX_DATA, 32'h0000005A);
		ticks(300);
		check_pin(sout, 1'b1);
		check_reg(32'(umpi_remote_model_inst.count_q), 32'(i));
		cts_n <= 1'b0;
		wait_tx(i);
		check_reg({24'h000000, umpi_remote_model_inst.got_q}, 32'h0000005A);
		// infrared with inverted input: a high resting line is no traffic
		wr(umpi_pkg::IDX_MODEM, 32'h00000044);
		ticks(4);
		check_pin(sout, 1'b0);
		ticks(200);
		rd(umpi_pkg::IDX_STATUS);
		check_reg(rdat & 32'h00000001, 32'h00000000);
		// a low level on the inverted input is a pulse, so a character of zeros arrives
		umpi_remote_model_inst.send(8'h00);
		ticks(40);
		rd(umpi_pkg::IDX_STATUS);
		check_reg(rdat & 32'h00000001, 32'h00000001);
		print_verdict();
	end
endmodule : uart_modem_pin_interface_tb_top
